// *** inc/iowd_pkg.sv ***
// package for the io card bus watchdog: constants, timing and state carriers
// assumes a single 25 MHz core clock and synchronous active-low reset
`default_nettype none
package iowd_pkg;
    // ************
    // timing
    // ************
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam logic [31:0] TRIP_TIMEOUT_RESET_NS = 32'h3B9A_CA00;
    localparam int unsigned PIN_COUNT = 72;
    localparam logic [31:0] CYCLE_ONE = 32'h0000_0001;
    localparam logic [31:0] CYCLE_ZERO = 32'h0000_0000;
    localparam logic [31:0] NS_ROUND = 32'h0000_0027;
    localparam logic [31:0] NS_PER_CYCLE = 32'h0000_0028;

    // ************
    // states, one-hot
    // ************
    typedef enum logic [1:0] {
        WD_RUN = 2'b01,
        WD_TRIPPED = 2'b10
    } iowd_state_type;

    typedef struct packed {
        logic [PIN_COUNT-1:0] value;
        logic [PIN_COUNT-1:0] enable;
    } iowd_pins_type;

    typedef struct packed {
        logic [31:0] limit;
        logic [31:0] elapsed;
        iowd_state_type state;
        logic tripped;
        logic hostLinkOn;
        logic tripPulse;
    } iowd_core_type;
endpackage
`default_nettype wire

// *** hw/iowd_sync.sv ***
// two-flop synchroniser for asynchronous level inputs
// assumes the input comes from outside the core clock domain
`default_nettype none
module iowd_sync import iowd_pkg::*; #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // data
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } iowd_sync_type;
    iowd_sync_type sync_reg;
    iowd_sync_type sync_next;

    always_comb begin
        sync_next.stage1 = asyncIn;
        sync_next.stage2 = sync_reg.stage1;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sync_reg <= '0;
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign syncOut = sync_reg.stage2;
endmodule
`default_nettype wire

// *** hw/iowd_watchdog.sv ***
// io card bus watchdog: times host refreshes and releases the io pins on trip
// assumes refresh, clear and timeout writes come from host logic on core_clk;
// io pad inputs are asynchronous and the pads add the weak pull-up
`default_nettype none
module iowd_watchdog import iowd_pkg::*; (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // host side
    input wire logic refreshStrobe,
    input wire logic timeoutWrite,
    input wire logic [31:0] timeoutData,
    input wire logic flagWrite,
    input wire logic flagData,
    output logic trippedFlag,
    output logic hostLinkOn,
    output logic [31:0] tripTimeout,
    // module side
    input wire iowd_pins_type modulePins,
    output logic [PIN_COUNT-1:0] padToModule,
    // io pads
    input wire logic [PIN_COUNT-1:0] padIn,
    output logic [PIN_COUNT-1:0] padOut,
    output logic [PIN_COUNT-1:0] padOe
);
    // ************
    // state
    // ************
    iowd_core_type core_reg;
    iowd_core_type core_next;
    iowd_pins_type pads_reg;
    iowd_pins_type pads_next;
    logic [31:0] timeout_reg;
    logic [31:0] timeout_next;
    logic [31:0] limitCalc;
    logic [PIN_COUNT-1:0] padSync;

    iowd_sync #(.WIDTH(PIN_COUNT)) u_pad_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .asyncIn(padIn),
        .syncOut(padSync)
    );

    // ************
    // next state
    // ************
    always_comb begin
        core_next = core_reg;
        pads_next = pads_reg;
        timeout_next = timeout_reg;
        limitCalc = CYCLE_ZERO;
        core_next.tripPulse = 1'b0;
        // timeout writes are accepted in either state
        if (timeoutWrite) begin
            timeout_next = timeoutData;
        end
        // ceiling of ns / period; a zero timeout still gives one cycle
        limitCalc = (timeout_reg / NS_PER_CYCLE)
            + ((timeout_reg % NS_PER_CYCLE) != CYCLE_ZERO ? CYCLE_ONE : CYCLE_ZERO);
        if (limitCalc == CYCLE_ZERO) begin
            limitCalc = CYCLE_ONE;
        end
        core_next.limit = limitCalc;
        case (core_reg.state)
            WD_RUN: begin
                if (refreshStrobe) begin
                    core_next.elapsed = CYCLE_ZERO;
                end else if (core_reg.elapsed >= core_reg.limit) begin
                    core_next.state = WD_TRIPPED;
                    core_next.tripped = 1'b1;
                    core_next.tripPulse = 1'b1;
                    core_next.hostLinkOn = 1'b0;
                end else begin
                    core_next.elapsed = core_reg.elapsed + CYCLE_ONE;
                end
            end
            WD_TRIPPED: begin
                // clear only honoured while the flag is true
                if (flagWrite && !flagData && core_reg.tripped) begin
                    core_next.state = WD_RUN;
                    core_next.tripped = 1'b0;
                    core_next.hostLinkOn = 1'b1;
                    core_next.elapsed = CYCLE_ZERO;
                end
            end
            default: begin
                core_next.state = WD_TRIPPED;
                core_next.tripped = 1'b1;
                core_next.hostLinkOn = 1'b0;
            end
        endcase
        // pins follow the state being entered, so release is same-cycle as flag
        if (core_next.state == WD_TRIPPED) begin
            pads_next.enable = '0;
            pads_next.value = '0;
        end else begin
            pads_next = modulePins;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            core_reg.limit <= CYCLE_ONE;
            core_reg.elapsed <= CYCLE_ZERO;
            core_reg.state <= WD_RUN;
            core_reg.tripped <= 1'b0;
            core_reg.hostLinkOn <= 1'b1;
            core_reg.tripPulse <= 1'b0;
            pads_reg <= '0;
            timeout_reg <= TRIP_TIMEOUT_RESET_NS;
        end else begin
            core_reg <= core_next;
            pads_reg <= pads_next;
            timeout_reg <= timeout_next;
        end
    end

    // ************
    // outputs
    // ************
    // modules always see the pads, so counters keep counting when tripped
    assign padToModule = padSync;
    assign padOut = pads_reg.value;
    assign padOe = pads_reg.enable;
    assign trippedFlag = core_reg.tripped;
    assign hostLinkOn = core_reg.hostLinkOn;
    assign tripTimeout = timeout_reg;

    // ************
    // assertions
    // ************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    trip_on_expiry_a: assert property (
        core_reg.state == WD_RUN && !refreshStrobe && core_reg.elapsed >= core_reg.limit
        |=> trippedFlag) else $error("no trip after timeout expiry");
    pins_released_a: assert property (
        trippedFlag |-> padOe == '0) else $error("pin driven while tripped");
    link_stopped_a: assert property (
        trippedFlag |-> !hostLinkOn) else $error("host link on while tripped");
    modules_see_pads_a: assert property (
        padToModule == $past(padIn, 2) || $past(!rst_n, 2))
        else $error("module input path broken");
    clear_restores_a: assert property (
        trippedFlag && flagWrite && !flagData
        |=> hostLinkOn && !trippedFlag && padOe == $past(modulePins.enable))
        else $error("clear did not restore");
    flag_sticky_a: assert property (
        trippedFlag && !(flagWrite && !flagData) |=> trippedFlag)
        else $error("tripped flag lost");
    timeout_write_a: assert property (
        timeoutWrite |=> tripTimeout == $past(timeoutData))
        else $error("timeout not stored");
    refresh_restart_a: assert property (
        !trippedFlag && refreshStrobe |=> !trippedFlag ##1 !trippedFlag)
        else $error("trip right after refresh");
    limit_round_a: assert property (
        ({32'h0000_0000, core_reg.limit} * {32'h0000_0000, NS_PER_CYCLE})
        >= {32'h0000_0000, $past(timeout_reg)} || $past(!rst_n))
        else $error("cycle limit rounds down");

    trip_seen_c: cover property (core_reg.tripPulse);
    clear_seen_c: cover property (trippedFlag ##1 !trippedFlag);
    refresh_seen_c: cover property (refreshStrobe && !trippedFlag);
    timeout_set_c: cover property (timeoutWrite ##[1:40] trippedFlag);
endmodule
`default_nettype wire

// *** testbench/iowd_host_model.sv ***
// host driver model: refresh pulse every fourth cycle
// assumes the core_clk domain and strobes sampled on the rising edge
`default_nettype none
module iowd_host_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // control and link
    input wire logic keepAlive,
    input wire logic hostLinkOn,
    output logic refreshStrobe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] tick;
    // silent while the link is down, as a real driver would be
    always_ff @(posedge core_clk) begin
        tick <= rst_n ? tick + 2'h1 : 2'h0;
        refreshStrobe <= rst_n && keepAlive && hostLinkOn && (tick == 2'h3);
    end
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking bench for the io card bus watchdog
// assumes a 25 MHz core clock and synchronous active-low reset
`default_nettype none
module testbench;
    import iowd_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0, rst_n = 1'b0, benchRefresh = 1'b0, keepAlive = 1'b0;
    logic timeoutWrite = 1'b0, flagWrite = 1'b0, flagData = 1'b0, modelRefresh;
    logic [31:0] timeoutData = 32'h0, tripTimeout;
    logic trippedFlag, hostLinkOn, refreshStrobe;
    iowd_pins_type modulePins = '0;
    logic [PIN_COUNT-1:0] padIn = '0, padToModule, padOut, padOe;
    int n_fail = 0, comparisons = 0, cyc = 0;
    assign refreshStrobe = benchRefresh | modelRefresh;
    always #20 core_clk = ~core_clk;
    iowd_watchdog dut (.core_clk(core_clk), .rst_n(rst_n), .refreshStrobe(refreshStrobe),
        .timeoutWrite(timeoutWrite), .timeoutData(timeoutData), .flagWrite(flagWrite),
        .flagData(flagData), .trippedFlag(trippedFlag), .hostLinkOn(hostLinkOn),
        .tripTimeout(tripTimeout), .modulePins(modulePins), .padToModule(padToModule),
        .padIn(padIn), .padOut(padOut), .padOe(padOe));
    iowd_host_model host (.core_clk(core_clk), .rst_n(rst_n), .keepAlive(keepAlive),
        .hostLinkOn(hostLinkOn), .refreshStrobe(modelRefresh));
    // ************
    // helpers
    // ************
    task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ************
    // scenarios
    // ************
    task automatic t_pads;
        @(posedge core_clk);
        modulePins <= '{value: {9{8'hC3}}, enable: {9{8'h5A}}};
        padIn <= {9{8'h96}};
        tick(2);
        check("padOut", padOut, {9{8'hC3}});
        check("padOe", padOe, {9{8'h5A}});
        check("padToModule", padToModule, {9{8'h96}});
        $display("test pads done");
    endtask
    // timeout 200 ns gives 5 cycles; trip lands 6 edges after refresh is taken
    task automatic t_trip;
        @(posedge core_clk);
        timeoutWrite <= 1'b1;
        timeoutData <= 32'h0000_00C8;
        @(posedge core_clk);
        timeoutWrite <= 1'b0;
        benchRefresh <= 1'b1;
        @(posedge core_clk);
        benchRefresh <= 1'b0;
        check("tripTimeout", tripTimeout, 32'h0000_00C8);
        tick(5);
        check("early flag", trippedFlag, 1'h0);
        tick(1);
        check("flag", trippedFlag, 1'h1);
        check("link", hostLinkOn, 1'h0);
        check("oe tripped", padOe, 72'h0);
        check("out tripped", padOut, 72'h0);
        @(posedge core_clk);
        padIn <= {9{8'h3C}};
        benchRefresh <= 1'b1;
        flagWrite <= 1'b1;
        flagData <= 1'b1;
        @(posedge core_clk);
        benchRefresh <= 1'b0;
        flagWrite <= 1'b0;
        tick(2);
        check("sync tripped", padToModule, {9{8'h3C}});
        check("flag held", trippedFlag, 1'h1);
        @(posedge core_clk);
        flagWrite <= 1'b1;
        flagData <= 1'b0;
        @(posedge core_clk);
        flagWrite <= 1'b0;
        tick(0);
        check("cleared", {trippedFlag, hostLinkOn}, 2'h1);
        check("oe back", padOe, {9{8'h5A}});
        check("out back", padOut, {9{8'hC3}});
        $display("test trip done");
    endtask
    task automatic t_keep;
        @(posedge core_clk);
        keepAlive <= 1'b1;
        tick(40);
        check("kept alive", trippedFlag, 1'h0);
        @(posedge core_clk);
        keepAlive <= 1'b0;
        tick(12);
        check("lapsed", trippedFlag, 1'h1);
        $display("test keep done");
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            close_out();
        end
    end
    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        tick(1);
        check("reset flag", {trippedFlag, hostLinkOn}, 2'h1);
        check("reset timeout", tripTimeout, TRIP_TIMEOUT_RESET_NS);
        t_pads();
        t_trip();
        t_keep();
        close_out();
    end
endmodule
`default_nettype wire
